// ==== src/pabm_map.svh ====
`ifndef PABM_MAP_SVH
`define PABM_MAP_SVH

`define PABM_PORT_W 8
`define PABM_PU_CODE 3'h2
`define PABM_BIT_SCK 7
`define PABM_BIT_MISO 6
`define PABM_BIT_MOSI 5
`define PABM_BIT_SS 4
`define PABM_BIT_T0OCA 3
`define PABM_BIT_CMPN 3
`define PABM_BIT_CMPP 2
`define PABM_BIT_IRQ2 2
`define PABM_BIT_DIVIDED_CLOCK_OUT 1
`define PABM_BIT_XCK 0
`define PABM_BYTE_RST 8'h00
`define PABM_OE_N_RST 8'hFF
`endif

// ==== src/pabm_pkg.sv ====
package pabm_pkg;
	typedef enum logic [1:0] {
		PABM_SPI_OFF = 2'h0,
		PABM_SPI_SLAVE = 2'h1,
		PABM_SPI_MASTER = 2'h2
	} pabm_spi_role_t;
	typedef logic [7:0] pabm_byte_t;
endpackage

// ==== src/pabm_pin_ctl.sv ====
`timescale 1ns/1ps
`include "pabm_map.svh"
module pabm_pin_ctl import pabm_pkg::*; #(
	parameter int W = 8
) (
	input wire logic [W-1:0] dir, // Direction bits
	input wire logic [W-1:0] out, // Port output bits
	input wire logic pud, // Global pull-up disable
	input wire logic [W-1:0] pu_oe, // Pull-up override enable
	input wire logic [W-1:0] pu_ov, // Pull-up override value
	input wire logic [W-1:0] dd_oe, // Direction override enable
	input wire logic [W-1:0] dd_ov, // Direction override value
	input wire logic [W-1:0] pv_oe, // Value override enable
	input wire logic [W-1:0] pv_ov, // Value override value
	output logic [W-1:0] pull_en, // Resolved pull-up
	output logic [W-1:0] drive, // Resolved output driver enable
	output logic [W-1:0] value // Resolved pad value
);
	if (W < 1) begin : g_bad_w
		$error("pabm_pin_ctl: W must be at least 1");
	end

	function automatic logic pick(input logic en, input logic ov, input logic dflt);
		pick = en ? ov : dflt;
	endfunction

	always_comb begin
		for (int i = 0; i < W; i++) begin
			pull_en[i] = pick(pu_oe[i], pu_ov[i], {dir[i], out[i], pud} == `PABM_PU_CODE);
			drive[i] = pick(dd_oe[i], dd_ov[i], dir[i]);
			value[i] = pick(pv_oe[i], pv_ov[i], out[i]);
		end
	end
endmodule // pabm_pin_ctl

// ==== src/pabm_din_gate.sv ====
`timescale 1ns/1ps
module pabm_din_gate import pabm_pkg::*; #(
	parameter int W = 8
) (
	input wire logic [W-1:0] pad, // Pad levels
	input wire logic sleep, // Sleep state disables inputs
	input wire logic [W-1:0] die_oe, // Input enable override enable
	input wire logic [W-1:0] die_ov, // Input enable override value
	output logic [W-1:0] din // Gated digital input
);
	if (W < 1) begin : g_bad_w
		$error("pabm_din_gate: W must be at least 1");
	end

	always_comb begin
		for (int i = 0; i < W; i++) begin
			din[i] = pad[i] & (die_oe[i] ? die_ov[i] : ~sleep);
		end
	end
endmodule // pabm_din_gate

// ==== src/pabm_port_mux.sv ====
`timescale 1ns/1ps
`include "pabm_map.svh"
module pabm_port_mux import pabm_pkg::*; #(
	parameter int PORT_W = `PABM_PORT_W
) (
	input wire logic mclk, // 25 MHz I/O clock
	input wire logic reset_n, // Synchronous reset, active low
	input wire logic pud, // Global pull-up disable
	input wire logic sleep, // Sleep state
	input wire logic [PORT_W-1:0] pa_dir, // First port direction bits
	input wire logic [PORT_W-1:0] pa_out, // First port output bits
	input wire logic [PORT_W-1:0] pa_pad_in, // First port pad levels
	input wire logic [PORT_W-1:0] pc_mask0, // Pin-change mask, group 0
	input wire logic pin_change_group0_enable, // Pin-change group 0 enable
	input wire logic [PORT_W-1:0] analog_din_disable_bit, // Converter digital input disable
	input wire logic [PORT_W-1:0] pb_dir, // Second port direction bits
	input wire logic [PORT_W-1:0] pb_out, // Second port output bits
	input wire logic [PORT_W-1:0] pb_pad_in, // Second port pad levels
	input wire logic [PORT_W-1:0] pc_mask1, // Pin-change mask, group 1
	input wire logic pin_change_group1_enable, // Pin-change group 1 enable
	input wire logic spi_enable, // SPI enabled
	input wire logic spi_master, // SPI master mode
	input wire logic spi_sck_out, // SPI master clock out
	input wire logic spi_slave_out, // SPI slave data out
	input wire logic spi_master_out, // SPI master data out
	input wire logic timer3_compare_b_out, // Timer3 compare B level
	input wire logic timer3_compare_b_en, // Timer3 compare B enabled
	input wire logic timer3_compare_a_out, // Timer3 compare A level
	input wire logic timer3_compare_a_en, // Timer3 compare A enabled
	input wire logic timer0_compare_b_out, // Timer0 compare B level
	input wire logic timer0_compare_b_en, // Timer0 compare B enabled
	input wire logic timer0_compare_a_out, // Timer0 compare A level
	input wire logic timer0_compare_a_en, // Timer0 compare A enabled
	input wire logic irq2_enable, // External interrupt 2 enabled
	input wire logic clock_out_fuse, // Divided clock output selected
	input wire logic divided_clock_level, // Divided clock level
	input wire logic usart0_sync_mode, // USART0 synchronous mode
	input wire logic usart0_clock_out, // USART0 clock level out
	output logic [PORT_W-1:0] pa_pad_out, // First port pad value
	output logic [PORT_W-1:0] pa_pad_oe_n, // First port driver enable, low drives
	output logic [PORT_W-1:0] pa_pullup_en, // First port pull-ups
	output logic [PORT_W-1:0] pa_din, // First port digital input
	output logic [PORT_W-1:0] adc_channel_in, // Converter channel taps 7:0
	output logic [2*PORT_W-1:0] pin_change_sources, // Pin-change sources 15:0
	output logic [PORT_W-1:0] pb_pad_out, // Second port pad value
	output logic [PORT_W-1:0] pb_pad_oe_n, // Second port driver enable, low drives
	output logic [PORT_W-1:0] pb_pullup_en, // Second port pull-ups
	output logic [PORT_W-1:0] pb_din, // Second port digital input
	output logic spi_sck_in, // SPI clock from pad
	output logic spi_master_in, // SPI master data in
	output logic spi_slave_in, // SPI slave data in
	output logic spi_select_n_in, // SPI select level, active low
	output logic spi_slave_active, // SPI slave selected
	output logic timer3_capture_in, // Timer3 capture trigger
	output logic comparator_neg_in, // Comparator negative tap
	output logic comparator_pos_in, // Comparator positive tap
	output logic external_irq_2, // External interrupt 2 input
	output logic timer1_count_in, // Timer1 count input
	output logic timer0_count_in, // Timer0 count input
	output logic usart0_ext_clock // USART0 clock from pad
);
	if (PORT_W != 8) begin : g_bad_w
		$error("pabm_port_mux: pin mapping needs PORT_W of 8");
	end

	pabm_spi_role_t spi_role;

	logic [PORT_W-1:0] pa_pu_oe, pa_pu_ov, pa_dd_oe, pa_dd_ov, pa_pv_oe, pa_pv_ov;
	logic [PORT_W-1:0] pa_die_oe, pa_die_ov;
	logic [PORT_W-1:0] pb_pu_oe, pb_pu_ov, pb_dd_oe, pb_dd_ov, pb_pv_oe, pb_pv_ov;
	logic [PORT_W-1:0] pb_die_oe, pb_die_ov;
	logic [PORT_W-1:0] pa_pull_w, pa_drive_w, pa_value_w, pa_din_w;
	logic [PORT_W-1:0] pb_pull_w, pb_drive_w, pb_value_w, pb_din_w;

	logic [PORT_W-1:0] pa_pad_out_reg, pa_pad_out_next;
	logic [PORT_W-1:0] pa_pad_oe_n_reg, pa_pad_oe_n_next;
	logic [PORT_W-1:0] pa_pullup_reg, pa_pullup_next;
	logic [PORT_W-1:0] pa_din_reg, pa_din_next;
	logic [PORT_W-1:0] adc_tap_reg, adc_tap_next;
	logic [2*PORT_W-1:0] pcint_reg, pcint_next;
	logic [PORT_W-1:0] pb_pad_out_reg, pb_pad_out_next;
	logic [PORT_W-1:0] pb_pad_oe_n_reg, pb_pad_oe_n_next;
	logic [PORT_W-1:0] pb_pullup_reg, pb_pullup_next;
	logic [PORT_W-1:0] pb_din_reg, pb_din_next;
	logic sck_in_reg, sck_in_next;
	logic m_in_reg, m_in_next;
	logic s_in_reg, s_in_next;
	logic ss_n_reg, ss_n_next;
	logic slave_act_reg, slave_act_next;
	logic cap3_reg, cap3_next;
	logic cmp_n_reg, cmp_n_next;
	logic cmp_p_reg, cmp_p_next;
	logic irq2_reg, irq2_next;
	logic t1_reg, t1_next;
	logic t0_reg, t0_next;
	logic xck_reg, xck_next;

	always_comb begin
		if (!spi_enable) begin
			spi_role = PABM_SPI_OFF;
		end else if (spi_master) begin
			spi_role = PABM_SPI_MASTER;
		end else begin
			spi_role = PABM_SPI_SLAVE;
		end
	end

	// First port: alternate functions never take the pin over
	always_comb begin
		pa_pu_oe = `PABM_BYTE_RST;
		pa_pu_ov = `PABM_BYTE_RST;
		pa_dd_oe = `PABM_BYTE_RST;
		pa_dd_ov = `PABM_BYTE_RST;
		pa_pv_oe = `PABM_BYTE_RST;
		pa_pv_ov = `PABM_BYTE_RST;
		pa_die_ov = pc_mask0 & {PORT_W{pin_change_group0_enable}};
		pa_die_oe = pa_die_ov | analog_din_disable_bit;
	end

	// Second port override table
	always_comb begin
		pb_pu_oe = `PABM_BYTE_RST;
		pb_pu_ov = `PABM_BYTE_RST;
		pb_dd_oe = `PABM_BYTE_RST;
		pb_dd_ov = `PABM_BYTE_RST;
		pb_pv_oe = `PABM_BYTE_RST;
		pb_pv_ov = `PABM_BYTE_RST;
		pb_die_ov = {PORT_W{1'b1}};
		pb_die_oe = pc_mask1 & {PORT_W{pin_change_group1_enable}};
		// Timer compare outputs; driver still needs the direction bit
		if (timer3_compare_b_en) begin
			pb_pv_oe[`PABM_BIT_SCK] = 1'b1;
			pb_pv_ov[`PABM_BIT_SCK] = timer3_compare_b_out;
		end
		if (timer3_compare_a_en) begin
			pb_pv_oe[`PABM_BIT_MISO] = 1'b1;
			pb_pv_ov[`PABM_BIT_MISO] = timer3_compare_a_out;
		end
		if (timer0_compare_b_en) begin
			pb_pv_oe[`PABM_BIT_SS] = 1'b1;
			pb_pv_ov[`PABM_BIT_SS] = timer0_compare_b_out;
		end
		if (timer0_compare_a_en) begin
			pb_pv_oe[`PABM_BIT_T0OCA] = 1'b1;
			pb_pv_ov[`PABM_BIT_T0OCA] = timer0_compare_a_out;
		end
		// SPI overrides take precedence over timer outputs
		case (spi_role)
			PABM_SPI_SLAVE: begin
				pb_dd_oe[`PABM_BIT_SCK] = 1'b1;
				pb_dd_ov[`PABM_BIT_SCK] = 1'b0;
				pb_pu_oe[`PABM_BIT_SCK] = 1'b1;
				pb_pu_ov[`PABM_BIT_SCK] = pb_out[`PABM_BIT_SCK] & ~pud;
				pb_dd_oe[`PABM_BIT_MOSI] = 1'b1;
				pb_dd_ov[`PABM_BIT_MOSI] = 1'b0;
				pb_pu_oe[`PABM_BIT_MOSI] = 1'b1;
				pb_pu_ov[`PABM_BIT_MOSI] = pb_out[`PABM_BIT_MOSI] & ~pud;
				pb_dd_oe[`PABM_BIT_SS] = 1'b1;
				pb_dd_ov[`PABM_BIT_SS] = 1'b0;
				pb_pu_oe[`PABM_BIT_SS] = 1'b1;
				pb_pu_ov[`PABM_BIT_SS] = pb_out[`PABM_BIT_SS] & ~pud;
				pb_pv_oe[`PABM_BIT_MISO] = 1'b1;
				pb_pv_ov[`PABM_BIT_MISO] = spi_slave_out;
			end
			PABM_SPI_MASTER: begin
				pb_dd_oe[`PABM_BIT_MISO] = 1'b1;
				pb_dd_ov[`PABM_BIT_MISO] = 1'b0;
				pb_pu_oe[`PABM_BIT_MISO] = 1'b1;
				pb_pu_ov[`PABM_BIT_MISO] = pb_out[`PABM_BIT_MISO] & ~pud;
				pb_pv_oe[`PABM_BIT_SCK] = 1'b1;
				pb_pv_ov[`PABM_BIT_SCK] = spi_sck_out;
				pb_pv_oe[`PABM_BIT_MOSI] = 1'b1;
				pb_pv_ov[`PABM_BIT_MOSI] = spi_master_out;
			end
			default: begin
			end
		endcase
		pb_die_oe[`PABM_BIT_IRQ2] = pb_die_oe[`PABM_BIT_IRQ2] | irq2_enable;
		if (clock_out_fuse) begin
			pb_dd_oe[`PABM_BIT_DIVIDED_CLOCK_OUT] = 1'b1;
			pb_dd_ov[`PABM_BIT_DIVIDED_CLOCK_OUT] = 1'b1;
			pb_pv_oe[`PABM_BIT_DIVIDED_CLOCK_OUT] = 1'b1;
			pb_pv_ov[`PABM_BIT_DIVIDED_CLOCK_OUT] = divided_clock_level;
		end
		// USART clock drives out only when the direction bit selects output
		if (usart0_sync_mode) begin
			pb_pv_oe[`PABM_BIT_XCK] = 1'b1;
			pb_pv_ov[`PABM_BIT_XCK] = usart0_clock_out;
		end
	end

	pabm_pin_ctl #(.W(PORT_W)) u_pa_ctl (
		.dir(pa_dir),
		.out(pa_out),
		.pud(pud),
		.pu_oe(pa_pu_oe),
		.pu_ov(pa_pu_ov),
		.dd_oe(pa_dd_oe),
		.dd_ov(pa_dd_ov),
		.pv_oe(pa_pv_oe),
		.pv_ov(pa_pv_ov),
		.pull_en(pa_pull_w),
		.drive(pa_drive_w),
		.value(pa_value_w)
	);

	pabm_pin_ctl #(.W(PORT_W)) u_pb_ctl (
		.dir(pb_dir),
		.out(pb_out),
		.pud(pud),
		.pu_oe(pb_pu_oe),
		.pu_ov(pb_pu_ov),
		.dd_oe(pb_dd_oe),
		.dd_ov(pb_dd_ov),
		.pv_oe(pb_pv_oe),
		.pv_ov(pb_pv_ov),
		.pull_en(pb_pull_w),
		.drive(pb_drive_w),
		.value(pb_value_w)
	);

	pabm_din_gate #(.W(PORT_W)) u_pa_din (
		.pad(pa_pad_in),
		.sleep(sleep),
		.die_oe(pa_die_oe),
		.die_ov(pa_die_ov),
		.din(pa_din_w)
	);

	pabm_din_gate #(.W(PORT_W)) u_pb_din (
		.pad(pb_pad_in),
		.sleep(sleep),
		.die_oe(pb_die_oe),
		.die_ov(pb_die_ov),
		.din(pb_din_w)
	);

	always_comb begin
		pa_pad_out_next = pa_value_w;
		pa_pad_oe_n_next = ~pa_drive_w;
		pa_pullup_next = pa_pull_w;
		pa_din_next = pa_din_w;
		adc_tap_next = pa_pad_in;
		pcint_next = {pb_din_w, pa_din_w};
		pb_pad_out_next = pb_value_w;
		pb_pad_oe_n_next = ~pb_drive_w;
		pb_pullup_next = pb_pull_w;
		pb_din_next = pb_din_w;
		sck_in_next = pb_din_w[`PABM_BIT_SCK];
		m_in_next = pb_din_w[`PABM_BIT_MISO];
		s_in_next = pb_din_w[`PABM_BIT_MOSI];
		ss_n_next = pb_din_w[`PABM_BIT_SS];
		slave_act_next = (spi_role == PABM_SPI_SLAVE) && !pb_din_w[`PABM_BIT_SS];
		cap3_next = pb_din_w[`PABM_BIT_MOSI];
		cmp_n_next = pb_pad_in[`PABM_BIT_CMPN];
		cmp_p_next = pb_pad_in[`PABM_BIT_CMPP];
		irq2_next = pb_din_w[`PABM_BIT_IRQ2];
		t1_next = pb_din_w[`PABM_BIT_DIVIDED_CLOCK_OUT];
		t0_next = pb_din_w[`PABM_BIT_XCK];
		xck_next = pb_din_w[`PABM_BIT_XCK];
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			pa_pad_out_reg <= `PABM_BYTE_RST;
			pa_pad_oe_n_reg <= `PABM_OE_N_RST;
			pa_pullup_reg <= `PABM_BYTE_RST;
			pa_din_reg <= `PABM_BYTE_RST;
			adc_tap_reg <= `PABM_BYTE_RST;
			pcint_reg <= '0;
			pb_pad_out_reg <= `PABM_BYTE_RST;
			pb_pad_oe_n_reg <= `PABM_OE_N_RST;
			pb_pullup_reg <= `PABM_BYTE_RST;
			pb_din_reg <= `PABM_BYTE_RST;
			sck_in_reg <= 1'b0;
			m_in_reg <= 1'b0;
			s_in_reg <= 1'b0;
			ss_n_reg <= 1'b1;
			slave_act_reg <= 1'b0;
			cap3_reg <= 1'b0;
			cmp_n_reg <= 1'b0;
			cmp_p_reg <= 1'b0;
			irq2_reg <= 1'b0;
			t1_reg <= 1'b0;
			t0_reg <= 1'b0;
			xck_reg <= 1'b0;
		end else begin
			pa_pad_out_reg <= pa_pad_out_next;
			pa_pad_oe_n_reg <= pa_pad_oe_n_next;
			pa_pullup_reg <= pa_pullup_next;
			pa_din_reg <= pa_din_next;
			adc_tap_reg <= adc_tap_next;
			pcint_reg <= pcint_next;
			pb_pad_out_reg <= pb_pad_out_next;
			pb_pad_oe_n_reg <= pb_pad_oe_n_next;
			pb_pullup_reg <= pb_pullup_next;
			pb_din_reg <= pb_din_next;
			sck_in_reg <= sck_in_next;
			m_in_reg <= m_in_next;
			s_in_reg <= s_in_next;
			ss_n_reg <= ss_n_next;
			slave_act_reg <= slave_act_next;
			cap3_reg <= cap3_next;
			cmp_n_reg <= cmp_n_next;
			cmp_p_reg <= cmp_p_next;
			irq2_reg <= irq2_next;
			t1_reg <= t1_next;
			t0_reg <= t0_next;
			xck_reg <= xck_next;
		end
	end

	assign pa_pad_out = pa_pad_out_reg;
	assign pa_pad_oe_n = pa_pad_oe_n_reg;
	assign pa_pullup_en = pa_pullup_reg;
	assign pa_din = pa_din_reg;
	assign adc_channel_in = adc_tap_reg;
	assign pin_change_sources = pcint_reg;
	assign pb_pad_out = pb_pad_out_reg;
	assign pb_pad_oe_n = pb_pad_oe_n_reg;
	assign pb_pullup_en = pb_pullup_reg;
	assign pb_din = pb_din_reg;
	assign spi_sck_in = sck_in_reg;
	assign spi_master_in = m_in_reg;
	assign spi_slave_in = s_in_reg;
	assign spi_select_n_in = ss_n_reg;
	assign spi_slave_active = slave_act_reg;
	assign timer3_capture_in = cap3_reg;
	assign comparator_neg_in = cmp_n_reg;
	assign comparator_pos_in = cmp_p_reg;
	assign external_irq_2 = irq2_reg;
	assign timer1_count_in = t1_reg;
	assign timer0_count_in = t0_reg;
	assign usart0_ext_clock = xck_reg;
endmodule // pabm_port_mux

// ==== sim/pabm_port_mux_assertions.sv ====
`timescale 1ns/1ps
module pabm_port_mux_chk import pabm_pkg::*; #(
	parameter int PORT_W = 8
) (
	input wire logic mclk, // Clock
	input wire logic reset_n, // Reset
	input wire logic pud, // Pull-up off
	input wire logic sleep, // Sleep
	input wire logic [PORT_W-1:0] pa_dir, // A dir
	input wire logic [PORT_W-1:0] pa_out, // A out
	input wire logic [PORT_W-1:0] pa_pad_in, // A pads
	input wire logic [PORT_W-1:0] pc_mask0, // A mask
	input wire logic pin_change_group0_enable, // A group
	input wire logic [PORT_W-1:0] analog_din_disable_bit, // A disable
	input wire logic [PORT_W-1:0] pb_out, // B out
	input wire logic [PORT_W-1:0] pb_pad_in, // B pads
	input wire logic spi_enable, // SPI on
	input wire logic spi_master, // SPI master
	input wire logic [PORT_W-1:0] pa_pad_out, // A value
	input wire logic [PORT_W-1:0] pa_pad_oe_n, // A drive
	input wire logic [PORT_W-1:0] pa_pullup_en, // A pull
	input wire logic [PORT_W-1:0] pa_din, // A input
	input wire logic [PORT_W-1:0] adc_channel_in, // A taps
	input wire logic [2*PORT_W-1:0] pin_change_sources, // Sources
	input wire logic [PORT_W-1:0] pb_pad_oe_n, // B drive
	input wire logic [PORT_W-1:0] pb_pullup_en, // B pull
	input wire logic [PORT_W-1:0] pb_din, // B input
	input wire logic spi_select_n_in, // Select
	input wire logic spi_slave_active, // Slave on
	input wire logic timer3_capture_in, // Capture
	input wire logic comparator_neg_in, // Cmp neg
	input wire logic comparator_pos_in, // Cmp pos
	input wire logic external_irq_2, // Irq 2
	input wire logic timer1_count_in, // T1 count
	input wire logic timer0_count_in // T0 count
);
	logic [PORT_W-1:0] pa_en;
	logic [PORT_W-1:0] pa_gate;
	assign pa_en = pc_mask0 & {PORT_W{pin_change_group0_enable}};
	assign pa_gate = pa_en | (~(pa_en | analog_din_disable_bit) & {PORT_W{~sleep}});
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	a_pa_fixed: assert property ($past(reset_n) |-> pa_pad_out == $past(pa_out) && pa_pad_oe_n == ~$past(pa_dir))
		else $error("port A pad mismatch");
	a_pa_pullup: assert property ($past(reset_n) |-> pa_pullup_en == $past(~pa_dir & pa_out & {PORT_W{~pud}}))
		else $error("port A pull-up mismatch");
	a_pa_din: assert property ($past(reset_n) |-> pa_din == $past(pa_gate & pa_pad_in))
		else $error("port A input mismatch");
	a_adc_raw: assert property ($past(reset_n) |-> adc_channel_in == $past(pa_pad_in))
		else $error("converter tap mismatch");
	a_slave_inputs: assert property (spi_enable && !spi_master |=> pb_pad_oe_n[7] && pb_pad_oe_n[5] && pb_pad_oe_n[4])
		else $error("slave pins driven");
	a_master_miso: assert property (spi_enable && spi_master |=> pb_pad_oe_n[6] && pb_pullup_en[6] == $past(pb_out[6] && !pud))
		else $error("master data pin wrong");
	a_slave_active: assert property ($past(reset_n) |-> spi_slave_active == ($past(spi_enable && !spi_master) && !spi_select_n_in))
		else $error("slave activity wrong");
	a_input_routes: assert property (pin_change_sources == {pb_din, pa_din} && timer3_capture_in == pb_din[5] && external_irq_2 == pb_din[2] && timer1_count_in == pb_din[1] && timer0_count_in == pb_din[0])
		else $error("input routing wrong");
	a_cmp_raw: assert property ($past(reset_n) |-> {comparator_neg_in, comparator_pos_in} == $past(pb_pad_in[3:2]))
		else $error("comparator tap wrong");
	cover property (spi_slave_active);
	cover property (spi_enable && spi_master);
	cover property (|pa_din);
endmodule // pabm_port_mux_chk
bind pabm_port_mux pabm_port_mux_chk #(.PORT_W(PORT_W)) pabm_port_mux_chk_i (.*);

// ==== sim/pabm_pad_model.sv ====
`timescale 1ns/1ps
module pabm_pad_model (
	input wire logic mclk, // Clock
	input wire logic [7:0] pad_out, // Design value
	input wire logic [7:0] pad_oe_n, // Low drives
	input wire logic [7:0] pull_en, // Pull-up on
	input wire logic [7:0] ext_drive, // Peer drives
	input wire logic [7:0] ext_level, // Peer level
	output logic [7:0] pad_in // Pad level
);
	logic [7:0] float_reg = 8'h00;
	// Floating pins change every cycle
	always @(posedge mclk) begin
		float_reg <= ~float_reg;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pad_oe_n[i]) begin
				pad_in[i] = pad_out[i];
			end else if (ext_drive[i]) begin
				pad_in[i] = ext_level[i];
			end else begin
				pad_in[i] = pull_en[i] | float_reg[i];
			end
		end
	end
endmodule // pabm_pad_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench import pabm_pkg::*;;
	logic mclk, reset_n, pud, sleep, pin_change_group0_enable, pin_change_group1_enable, spi_enable, spi_master;
	logic spi_sck_out, spi_slave_out, spi_master_out, timer3_compare_b_out, timer3_compare_b_en;
	logic timer3_compare_a_out, timer3_compare_a_en, timer0_compare_b_out, timer0_compare_b_en;
	logic timer0_compare_a_out, timer0_compare_a_en, irq2_enable, clock_out_fuse, divided_clock_level;
	logic usart0_sync_mode, usart0_clock_out;
	pabm_byte_t pa_dir, pa_out, pa_pad_in, pc_mask0, analog_din_disable_bit, pb_dir, pb_out, pb_pad_in, pc_mask1;
	pabm_byte_t pa_pad_out, pa_pad_oe_n, pa_pullup_en, pa_din, adc_channel_in, pb_pad_out, pb_pad_oe_n;
	pabm_byte_t pb_pullup_en, pb_din, ext_drive, ext_level;
	logic [15:0] pin_change_sources;
	logic spi_sck_in, spi_master_in, spi_slave_in, spi_select_n_in, spi_slave_active, timer3_capture_in;
	logic comparator_neg_in, comparator_pos_in, external_irq_2, timer1_count_in, timer0_count_in, usart0_ext_clock;
	int mismatches, comparisons, cycles;
	pabm_port_mux pabm_port_mux_i (.*);
	pabm_pad_model pabm_pad_model_i (.mclk(mclk), .pad_out(pb_pad_out), .pad_oe_n(pb_pad_oe_n),
		.pull_en(pb_pullup_en), .ext_drive(ext_drive), .ext_level(ext_level), .pad_in(pb_pad_in));
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic settle;
		repeat (3) @(posedge mclk);
		#1;
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 1000) begin
			mismatches++;
			final_report();
		end
	end
	task automatic t_port_a;
		{pa_dir, pa_out, pa_pad_in, pc_mask0, analog_din_disable_bit} = {8'hF0, 8'hCC, 8'hA5, 8'h0F, 8'h30};
		pin_change_group0_enable = 1'b1;
		sleep = 1'b1;
		settle();
		chk(pa_pad_out, 8'hCC);
		chk(pa_pad_oe_n, 8'h0F);
		chk(pa_pullup_en, 8'h0C);
		chk(pa_din, 8'h05);
		chk(adc_channel_in, 8'hA5);
		chk(pin_change_sources[7:0], 8'h05);
		pud = 1'b1;
		sleep = 1'b0;
		settle();
		chk(pa_pullup_en, 8'h00);
		chk(pa_din, 8'h85);
		pud = 1'b0;
		$display("port A test done");
	endtask
	task automatic t_spi_slave;
		{spi_enable, spi_master, spi_slave_out} = 3'h5;
		{pb_dir, pb_out, ext_drive, ext_level} = {8'hFF, 8'hF0, 8'hFF, 8'h0F};
		settle();
		chk(pb_pad_oe_n[7:4], 4'hB);
		chk(pb_pullup_en[7:4], 4'hB);
		chk(pb_pad_out[6], 1'h1);
		chk(spi_slave_active, 1'h1);
		ext_level = 8'hBF;
		settle();
		chk(spi_slave_active, 1'h0);
		chk({spi_sck_in, spi_slave_in}, 2'h3);
		$display("SPI slave test done");
	endtask
	task automatic t_spi_master;
		{spi_master, spi_sck_out, spi_master_out} = 3'h6;
		{pb_dir, pb_out} = {8'hF0, 8'h40};
		settle();
		chk(pb_pad_oe_n[7:4], 4'h4);
		chk(pb_pullup_en[6], 1'h1);
		chk(pb_pad_out[7:5], 3'h6);
		chk(spi_master_in, 1'h0);
		chk(spi_slave_active, 1'h0);
		$display("SPI master test done");
	endtask
	task automatic t_timers;
		spi_enable = 1'b0;
		{pb_dir, pb_out} = {8'hD8, 8'h00};
		{timer3_compare_b_en, timer3_compare_b_out, timer3_compare_a_en, timer3_compare_a_out} = 4'hE;
		{timer0_compare_b_en, timer0_compare_b_out, timer0_compare_a_en, timer0_compare_a_out} = 4'hF;
		settle();
		chk(pb_pad_oe_n[7:3], 5'h04);
		chk(pb_pad_out[7:3], 5'h13);
		{timer3_compare_b_en, timer3_compare_a_en, timer0_compare_b_en, timer0_compare_a_en} = 4'h0;
		{pb_dir, pb_out} = {8'hFF, 8'hA5};
		settle();
		chk(pb_pad_oe_n, 8'h00);
		chk(pb_pad_out, 8'hA5);
		$display("timer test done");
	endtask
	task automatic t_misc;
		{pb_dir, pb_out, ext_drive, ext_level, pc_mask1} = {8'h01, 8'h00, 8'hFC, 8'h24, 8'h20};
		{clock_out_fuse, divided_clock_level, usart0_sync_mode, usart0_clock_out} = 4'hF;
		{irq2_enable, pin_change_group1_enable, sleep} = 3'h7;
		settle();
		chk(pb_pad_oe_n[1:0], 2'h0);
		chk(pb_pad_out[1:0], 2'h3);
		chk(pb_din, 8'h24);
		chk({timer3_capture_in, external_irq_2}, 2'h3);
		chk(pin_change_sources[15:8], 8'h24);
		chk({comparator_neg_in, comparator_pos_in}, 2'h1);
		sleep = 1'b0;
		settle();
		chk(pin_change_sources[15:8], 8'h27);
		chk({timer1_count_in, timer0_count_in, usart0_ext_clock}, 3'h7);
		$display("misc test done");
	endtask
	initial begin
		{reset_n, pud, sleep, pin_change_group0_enable, pin_change_group1_enable, spi_enable, spi_master} = '0;
		{spi_sck_out, spi_slave_out, spi_master_out, timer3_compare_b_out, timer3_compare_b_en} = '0;
		{timer3_compare_a_out, timer3_compare_a_en, timer0_compare_b_out, timer0_compare_b_en} = '0;
		{timer0_compare_a_out, timer0_compare_a_en, irq2_enable, clock_out_fuse, divided_clock_level} = '0;
		{usart0_sync_mode, usart0_clock_out, pa_dir, pa_out, pa_pad_in, pc_mask0} = '0;
		{analog_din_disable_bit, pb_dir, pb_out, pc_mask1, ext_level} = '0;
		ext_drive = 8'hFF;
		{mismatches, comparisons, cycles} = '0;
		repeat (12) @(posedge mclk);
		#1;
		chk({pa_pad_oe_n, pb_pad_oe_n}, 16'hFFFF);
		chk(spi_select_n_in, 1'h1);
		reset_n = 1'b1;
		t_port_a();
		t_spi_slave();
		t_spi_master();
		t_timers();
		t_misc();
		final_report();
	end
endmodule // testbench
